//--- fcr_regs.sv
// APB register bank and per-PWM-cycle angle source engine.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module fcr_regs
  import fcr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        pwm_tick,
  input  wire logic [15:0] estimated_angle,
  input  wire logic        est_speed_below_min,
  input  wire logic [15:0] forced_speed_increment,
  input  wire logic [15:0] forced_speed_hold,
  output logic             overmod_enable,
  output logic             space_vector_select,
  output logic             sine_polarity_select,
  output logic [1:0]       shunt_topology,
  output logic             estimator_type_select,
  output logic             q_pi_disable,
  output logic             d_pi_disable,
  output logic             alternate_sampling_select,
  output logic             discontinuous_sv_active,
  output logic             sample_phase_toggle,
  output logic             phase_peak_clear,
  output logic [14:0]      offset_a,
  output logic [14:0]      offset_b,
  output logic [14:0]      offset_c,
  output logic [7:0]       sample_window_min,
  output logic [7:0]       narrow_pulse_threshold,
  output logic [7:0]       sample_blanking_time,
  output logic [8:0]       trigger_delay_cycles,
  output logic             ramp_active,
  output logic [15:0]      angle_out,
  output fcr_src_t         angle_source
);

  // *****************************************************************
  // State
  // *****************************************************************
  typedef struct packed {
    logic [7:0]  cr1;
    logic [7:0]  cr2;
    logic [7:0]  wmin;
    logic [7:0]  npt;
    logic [7:0]  blank;
    logic [7:0]  tdly;
    logic [14:0] ofs_a;
    logic [14:0] ofs_b;
    logic [14:0] ofs_c;
    logic [31:0] speed;
    logic [15:0] accel;
    logic [7:0]  rcnt;
    logic [7:0]  step;
    logic [15:0] ramp_ctr;
    logic [15:0] ol;
    logic [15:0] fspeed;
    logic [15:0] fangle;
    fcr_src_t    src;
    logic [15:0] angle;
    logic [8:0]  dly;
    logic        dsv;
    logic        phase;
    logic        pclr;
    logic        pready;
    logic        pslverr;
    logic [7:0]  prdata;
  } fcr_state_t;

  fcr_state_t  s_r;
  fcr_state_t  s_nxt;
  logic [15:0] idx;
  logic        acc;
  logic        wr;
  logic        hit;
  logic [7:0]  rd;
  logic [14:0] ofs_sel;
  logic [31:0] nspeed;
  logic [16:0] ctr_inc;
  logic [16:0] fsum;
  logic [15:0] diff;
  logic [15:0] mag;
  logic [15:0] fsp;

  assign idx = paddr[17:2];
  assign acc = psel & penable;
  assign wr  = acc & s_r.pready & pwrite & pstrb[0] & hit;
  assign hit = (paddr[1:0] == 2'h0) && (idx >= IDX_CR1) && (idx <= IDX_STEP);

  // *****************************************************************
  // Read multiplexer
  // *****************************************************************
  always_comb begin
    case (s_r.cr2[3:2])
      TGT_A:   ofs_sel = s_r.ofs_a;
      TGT_B:   ofs_sel = s_r.ofs_b;
      default: ofs_sel = s_r.ofs_c;
    endcase
    case (idx)
      IDX_CR1:   rd = s_r.cr1;
      IDX_CR2:   rd = s_r.cr2;
      IDX_WMIN:  rd = s_r.wmin;
      IDX_NPT:   rd = s_r.npt;
      IDX_BLANK: rd = s_r.blank;
      IDX_TDLY:  rd = s_r.tdly;
      IDX_OFS_H: rd = {1'b0, ofs_sel[14:8]};
      IDX_OFS_L: rd = ofs_sel[7:0];
      IDX_SPD_H: rd = s_r.speed[31:24];
      IDX_SPD_L: rd = s_r.speed[23:16];
      IDX_ACC_H: rd = s_r.accel[15:8];
      IDX_ACC_L: rd = s_r.accel[7:0];
      IDX_RCNT:  rd = s_r.rcnt;
      IDX_STEP:  rd = s_r.step;
      default:   rd = RST_ZERO;
    endcase
  end

  // *****************************************************************
  // Next state
  // *****************************************************************
  always_comb begin
    s_nxt   = s_r;
    nspeed  = s_r.speed + {16'h0, s_r.accel};
    ctr_inc = {1'b0, s_r.ramp_ctr} + 17'h1;
    diff    = estimated_angle - s_r.ol;
    mag     = diff[15] ? (16'h0 - diff) : diff;
    fsum    = {1'b0, s_r.fspeed} + {1'b0, forced_speed_increment};
    fsp     = (fsum > {1'b0, forced_speed_hold}) ? forced_speed_hold : fsum[15:0];

    // One wait state: the answer comes in the second access cycle.
    s_nxt.pready = acc & ~s_r.pready;
    if (acc & ~s_r.pready) begin
      s_nxt.pslverr = ~hit;
      s_nxt.prdata  = hit ? rd : RST_ZERO;
    end

    // Peak clear lasts one cycle, then the bit returns to zero.
    s_nxt.pclr = s_r.cr2[B_PCLR];
    if (s_r.cr2[B_PCLR]) begin
      s_nxt.cr2[B_PCLR] = 1'b0;
    end

    // Discontinuous mode is withheld from the driver in single shunt,
    // so a wrong setting cannot corrupt the single sample point.
    s_nxt.dsv = s_r.cr2[B_DSV] & (s_r.cr1[3:2] != TOPO_SINGLE);
    if (s_r.cr1[3:2] == TOPO_SINGLE) begin
      s_nxt.dly = {s_r.tdly[7], s_r.tdly};
    end else if (s_r.tdly[7]) begin
      s_nxt.dly = 9'h000 - {2'h0, s_r.tdly[6:0]};
    end else begin
      s_nxt.dly = {2'h0, s_r.tdly[6:0]};
    end

    if (!s_r.cr1[B_RAMP]) begin
      s_nxt.ramp_ctr = 16'h0000;
    end

    if (pwm_tick) begin
      if (s_r.cr2[B_ALT] && (s_r.cr1[3:2] != TOPO_SINGLE)) begin
        s_nxt.phase = ~s_r.phase;
      end
      if (s_r.src != SRC_FORCED) begin
        s_nxt.fspeed = 16'h0000;
      end
      if (s_r.cr1[B_RAMP]) begin
        s_nxt.speed = nspeed;
        s_nxt.ol    = s_r.ol + nspeed[31:16];
        s_nxt.angle = s_r.ol + nspeed[31:16];
        s_nxt.src   = SRC_RAMP;
        if (ctr_inc >= {1'b0, s_r.rcnt, 8'h00}) begin
          s_nxt.cr1[B_RAMP] = 1'b0;
          s_nxt.ramp_ctr    = 16'h0000;
        end else begin
          s_nxt.ramp_ctr = ctr_inc[15:0];
        end
      end else if (!s_r.cr1[B_ANGLE_SOURCE_SELECT]) begin
        s_nxt.ol    = s_r.ol + s_r.speed[31:16];
        s_nxt.angle = s_r.ol + s_r.speed[31:16];
        s_nxt.src   = SRC_PULL;
      end else if ((s_r.src == SRC_RAMP) || (s_r.src == SRC_SMOOTH)) begin
        if (mag <= {8'h00, s_r.step}) begin
          s_nxt.angle = estimated_angle;
          s_nxt.src   = SRC_EST;
        end else if (diff[15]) begin
          s_nxt.ol    = s_r.ol - {8'h00, s_r.step};
          s_nxt.angle = s_r.ol - {8'h00, s_r.step};
          s_nxt.src   = SRC_SMOOTH;
        end else begin
          s_nxt.ol    = s_r.ol + {8'h00, s_r.step};
          s_nxt.angle = s_r.ol + {8'h00, s_r.step};
          s_nxt.src   = SRC_SMOOTH;
        end
      end else if (s_r.cr1[B_ESTIMATOR_FORCED_START_EN] && est_speed_below_min) begin
        s_nxt.fspeed = (s_r.src == SRC_FORCED) ? fsp : 16'h0000;
        s_nxt.fangle = s_r.fangle + s_nxt.fspeed;
        s_nxt.angle  = s_r.fangle + s_nxt.fspeed;
        s_nxt.src    = SRC_FORCED;
      end else begin
        s_nxt.angle = estimated_angle;
        s_nxt.fangle = estimated_angle;
        s_nxt.src   = SRC_EST;
      end
    end

    // Software writes come last so that a write wins over any
    // hardware update landing in the same cycle.
    if (wr) begin
      case (idx)
        IDX_CR1:   s_nxt.cr1 = pwdata[7:0];
        IDX_CR2:   s_nxt.cr2 = pwdata[7:0] | {1'b0, s_nxt.cr2[B_PCLR], 6'h00};
        IDX_WMIN:  s_nxt.wmin = pwdata[7:0];
        IDX_NPT:   s_nxt.npt = pwdata[7:0];
        IDX_BLANK: s_nxt.blank = pwdata[7:0];
        IDX_TDLY:  s_nxt.tdly = pwdata[7:0];
        IDX_OFS_H: begin
          case (s_r.cr2[3:2])
            TGT_A:   s_nxt.ofs_a[14:8] = pwdata[6:0];
            TGT_B:   s_nxt.ofs_b[14:8] = pwdata[6:0];
            default: s_nxt.ofs_c[14:8] = pwdata[6:0];
          endcase
        end
        IDX_OFS_L: begin
          case (s_r.cr2[3:2])
            TGT_A:   s_nxt.ofs_a[7:0] = pwdata[7:0];
            TGT_B:   s_nxt.ofs_b[7:0] = pwdata[7:0];
            default: s_nxt.ofs_c[7:0] = pwdata[7:0];
          endcase
        end
        IDX_SPD_H: begin
          s_nxt.speed[31:24] = pwdata[7:0];
          s_nxt.speed[15:0]  = 16'h0000;
        end
        IDX_SPD_L: s_nxt.speed[23:16] = pwdata[7:0];
        IDX_ACC_H: s_nxt.accel[15:8] = pwdata[7:0];
        IDX_ACC_L: s_nxt.accel[7:0] = pwdata[7:0];
        IDX_RCNT:  s_nxt.rcnt = pwdata[7:0];
        IDX_STEP:  s_nxt.step = pwdata[7:0];
        default:   s_nxt.rcnt = s_nxt.rcnt;
      endcase
    end
  end

  // *****************************************************************
  // Register
  // *****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r          <= '0;
      s_r.ofs_a    <= RST_OFS;
      s_r.ofs_b    <= RST_OFS;
      s_r.ofs_c    <= RST_OFS;
      s_r.step     <= RST_STEP;
      s_r.src      <= SRC_PULL;
    end else begin
      s_r <= s_nxt;
    end
  end

  // *****************************************************************
  // Outputs
  // *****************************************************************
  assign pready                    = s_r.pready;
  assign prdata                    = {24'h000000, s_r.prdata};
  assign pslverr                   = s_r.pslverr;
  assign overmod_enable            = s_r.cr1[B_OVM];
  assign space_vector_select       = s_r.cr1[0];
  assign sine_polarity_select      = s_r.cr1[1];
  assign shunt_topology            = s_r.cr1[3:2];
  assign estimator_type_select     = s_r.cr2[B_ESTIMATOR_TYPE_SELECT];
  assign q_pi_disable              = s_r.cr2[B_QD];
  assign d_pi_disable              = s_r.cr2[B_DD];
  assign alternate_sampling_select = s_r.cr2[B_ALT];
  assign discontinuous_sv_active   = s_r.dsv;
  assign sample_phase_toggle       = s_r.phase;
  assign phase_peak_clear          = s_r.pclr;
  assign offset_a                  = s_r.ofs_a;
  assign offset_b                  = s_r.ofs_b;
  assign offset_c                  = s_r.ofs_c;
  assign sample_window_min         = s_r.wmin;
  assign narrow_pulse_threshold    = s_r.npt;
  assign sample_blanking_time      = s_r.blank;
  assign trigger_delay_cycles      = s_r.dly;
  assign ramp_active               = s_r.cr1[B_RAMP];
  assign angle_out                 = s_r.angle;
  assign angle_source              = s_r.src;

  // *****************************************************************
  // Checks
  // *****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_ramp_end_clear: assert property (
    pwm_tick && s_r.cr1[B_RAMP] && (ctr_inc >= {1'b0, s_r.rcnt, 8'h00}) && !wr
    |=> !s_r.cr1[B_RAMP] && (s_r.ramp_ctr == 16'h0000))
    else $error("ramp did not end at its count");

  chk_peak_clear_pulse: assert property (
    $rose(s_r.cr2[B_PCLR]) |=> phase_peak_clear ##1 !phase_peak_clear)
    else $error("peak clear pulse wrong");

  chk_offset_msb_zero: assert property (
    pready && !pwrite && (idx == IDX_OFS_H) |-> prdata[7] == 1'b0)
    else $error("offset msb read as one");

  chk_upper_read_zero: assert property (
    pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  chk_unmapped_error: assert property (
    acc && !pready && !hit |=> pready && pslverr)
    else $error("unmapped access not flagged");

  chk_single_no_disc: assert property (
    (shunt_topology == TOPO_SINGLE) |=> !discontinuous_sv_active)
    else $error("discontinuous mode in single shunt");

  chk_alt_toggle: assert property (
    pwm_tick && s_r.cr2[B_ALT] && (shunt_topology != TOPO_SINGLE)
    |=> sample_phase_toggle != $past(sample_phase_toggle))
    else $error("alternate phase did not toggle");

  chk_delay_sign_mag: assert property (
    (shunt_topology != TOPO_SINGLE) && s_r.tdly[7] && $stable(s_r.tdly) && $stable(shunt_topology)
    |=> $signed(trigger_delay_cycles) == -$signed({2'h0, $past(s_r.tdly[6:0])}))
    else $error("sign-magnitude delay wrong");

  chk_forced_cap: assert property (
    pwm_tick && (s_r.src == SRC_FORCED) && s_r.cr1[B_ESTIMATOR_FORCED_START_EN] && est_speed_below_min
    && !s_r.cr1[B_RAMP] && s_r.cr1[B_ANGLE_SOURCE_SELECT]
    |=> s_r.fspeed <= $past(forced_speed_hold))
    else $error("forced speed above hold");

  chk_pull_advance: assert property (
    pwm_tick && !s_r.cr1[B_RAMP] && !s_r.cr1[B_ANGLE_SOURCE_SELECT]
    |=> (angle_out == $past(s_r.ol) + $past(s_r.speed[31:16])) && (angle_source == SRC_PULL))
    else $error("pulling angle did not advance");

  chk_smooth_done: assert property (
    pwm_tick && (s_r.src == SRC_SMOOTH) && !s_r.cr1[B_RAMP] && s_r.cr1[B_ANGLE_SOURCE_SELECT]
    && (mag <= {8'h00, s_r.step})
    |=> (angle_source == SRC_EST) && (angle_out == $past(estimated_angle)))
    else $error("smooth switch did not hand over");

  chk_ready_one_wait: assert property (
    acc && !pready |=> pready ##1 !pready)
    else $error("ready not after exactly one wait state");

  chk_step_write: assert property (
    wr && (idx == IDX_STEP) |=> s_r.step == $past(pwdata[7:0]))
    else $error("step write lost");

  chk_peak_bit_clears: assert property (
    s_r.cr2[B_PCLR] && !wr |=> !s_r.cr2[B_PCLR])
    else $error("peak clear bit did not return to zero");

  chk_ramp_source: assert property (
    pwm_tick && s_r.cr1[B_RAMP] |=> angle_source == SRC_RAMP)
    else $error("ramp did not drive the angle");

  cov_forced_to_est: cover property (
    (s_r.src == SRC_FORCED) ##1 (s_r.src == SRC_EST));
  cov_ramp_done: cover property (
    s_r.cr1[B_RAMP] ##1 !s_r.cr1[B_RAMP]);
  cov_smooth: cover property (
    (s_r.src == SRC_SMOOTH) ##[1:50] (s_r.src == SRC_EST));
  cov_forced: cover property (
    s_r.src == SRC_FORCED);
  cov_bad_addr: cover property (
    pready && pslverr);

endmodule : fcr_regs

//--- fcr_pkg.sv
// Constants and types shared by the motor-control angle and ramp register bank.
// Function
// - Control bit 7 enables overmodulation
// - Forced-start enable forces angle at low estimated speed
// - Ramp enable drives angle, self-clears when done
// - Angle-mode bit picks pulling or estimator angle
// - Topology field: 00 single, 01 dual, 11 triple
// - Bit 0 space-vector, bit 1 bipolar sine
// - Bit 7 selects sliding-mode or PLL estimator
// - Peak-clear bit zeroes peaks, then self-clears
// - Discontinuous space-vector never with single shunt
// - Alternate sampling: one phase per cycle, alternating
// - Offset target field steers offset writes
// - Bits 1/0 freeze q/d PI voltage updates
// - Minimum window register feeds sampling window
// - Narrow-pulse threshold suppresses short high-side pulses
// - Blanking register skips short low-side samples
// - Zero delay samples at nominal midpoint
// - Single-shunt delay is two's complement
// - Dual/triple delay is sign-magnitude
// - Offset reads MSB zero, range 0..32767
// - Speed accumulates acceleration, angle accumulates speed
// - Ramp ends after count times 256 cycles
// - Correction step unsigned, resets to one
// - Smooth switch steps toward estimated angle
// - Forced speed rises by increment, capped
package fcr_pkg;

  // *****************************************************************
  // Register indices (byte address is four times the index)
  // *****************************************************************
  localparam logic [15:0] IDX_CR1   = 16'h40A0;
  localparam logic [15:0] IDX_CR2   = 16'h40A1;
  localparam logic [15:0] IDX_WMIN  = 16'h40A2;
  localparam logic [15:0] IDX_NPT   = 16'h40A3;
  localparam logic [15:0] IDX_BLANK = 16'h40A4;
  localparam logic [15:0] IDX_TDLY  = 16'h40A5;
  localparam logic [15:0] IDX_OFS_H = 16'h40A6;
  localparam logic [15:0] IDX_OFS_L = 16'h40A7;
  localparam logic [15:0] IDX_SPD_H = 16'h40A8;
  localparam logic [15:0] IDX_SPD_L = 16'h40A9;
  localparam logic [15:0] IDX_ACC_H = 16'h40AA;
  localparam logic [15:0] IDX_ACC_L = 16'h40AB;
  localparam logic [15:0] IDX_RCNT  = 16'h40AC;
  localparam logic [15:0] IDX_STEP  = 16'h40AD;

  // *****************************************************************
  // Reset values, field positions and codes
  // *****************************************************************
  localparam logic [7:0]  RST_ZERO  = 8'h00;
  localparam logic [7:0]  RST_STEP  = 8'h01;
  localparam logic [14:0] RST_OFS   = 15'h4000;
  localparam int B_OVM  = 7;
  localparam int B_ESTIMATOR_FORCED_START_EN = 6;
  localparam int B_RAMP = 5;
  localparam int B_ANGLE_SOURCE_SELECT = 4;
  localparam int B_ESTIMATOR_TYPE_SELECT = 7;
  localparam int B_PCLR = 6;
  localparam int B_DSV  = 5;
  localparam int B_ALT  = 4;
  localparam int B_QD   = 1;
  localparam int B_DD   = 0;
  localparam logic [1:0] TOPO_SINGLE = 2'h0;
  localparam logic [1:0] TGT_A       = 2'h1;
  localparam logic [1:0] TGT_B       = 2'h2;
  localparam int RAMP_CNT_SHIFT = 8;

  // *****************************************************************
  // Timing
  // *****************************************************************
  localparam int CLK_PERIOD_PS = 50000;
  localparam int BLANK_UNIT_PS = 41670;
  // A count of blanking units never spans less than one bus clock.
  localparam int BLANK_UNIT_CYC = (BLANK_UNIT_PS / CLK_PERIOD_PS) < 1 ? 1 : (BLANK_UNIT_PS / CLK_PERIOD_PS);

  typedef enum logic [2:0] {SRC_PULL, SRC_RAMP, SRC_SMOOTH, SRC_EST, SRC_FORCED} fcr_src_t;

endpackage : fcr_pkg

//--- fcr_pwm_partner.sv
// Behavioural PWM timer and estimator seen from the register bank.
`timescale 1ns/1ps
module fcr_pwm_partner (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        tick_en,
  input  wire logic [15:0] est_set,
  output logic             pwm_tick,
  output logic [15:0]      estimated_angle
);
  int cnt;

  // ****************************************************************
  // Carrier period ticks
  // ****************************************************************
  // The period varies so the engine meets both short and long cycles.
  // Ticks stop while software reloads parameter pairs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt             <= 0;
      pwm_tick        <= 1'b0;
      estimated_angle <= 16'h0000;
    end else begin
      pwm_tick        <= 1'b0;
      estimated_angle <= est_set;
      if (tick_en) begin
        if (cnt == 0) begin
          pwm_tick <= 1'b1;
          cnt      <= 2 + $urandom_range(0, 4);
        end else begin
          cnt <= cnt - 1;
        end
      end
    end
  end
endmodule : fcr_pwm_partner

//--- fcr_regs_tb_top.sv
// Self-checking bench for the angle and ramp register bank.
`timescale 1ns/1ps
module fcr_regs_tb_top
  import fcr_pkg::*;
;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        tick_en = 0, below = 0;
  logic [17:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, seed;
  logic [3:0]  pstrb = 0;
  logic [15:0] est_set = 0, finc = 0, fhold = 0, est, angle_out, w16;
  logic        pready, pslverr, pwm_tick, ovm, svs, sps, ets, qpd, dpd, alt, dsv, tog, ppc, ract;
  logic [1:0]  topo;
  logic [14:0] ofa, ofb, ofc, mo [3];
  logic [7:0]  wmin, npt, blk, c1, c2, v, stp, m_c1, m_c2, m_rc, m_stp;
  logic [8:0]  tdc;
  fcr_src_t    src, m_src;
  logic [31:0] m_spd;
  logic [15:0] m_ol, m_ang, m_acc, m_fa;
  logic        m_post, m_tog;
  int          m_fs, m_cnt, num_errors = 0, checks = 0, cyc = 0, pc = 0, k0;
  logic [7:0]  rv [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                           8'h00, 8'h01};
  logic [7:0]  dl [6] = '{8'h00, 8'h05, 8'hFB, 8'h85, 8'h7F, 8'h80};

  fcr_regs u_fcr_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pwm_tick(pwm_tick), .estimated_angle(est), .est_speed_below_min(below), .forced_speed_increment(finc),
    .forced_speed_hold(fhold), .overmod_enable(ovm), .space_vector_select(svs), .sine_polarity_select(sps),
    .shunt_topology(topo), .estimator_type_select(ets), .q_pi_disable(qpd), .d_pi_disable(dpd),
    .alternate_sampling_select(alt), .discontinuous_sv_active(dsv), .sample_phase_toggle(tog),
    .phase_peak_clear(ppc), .offset_a(ofa), .offset_b(ofb), .offset_c(ofc), .sample_window_min(wmin),
    .narrow_pulse_threshold(npt), .sample_blanking_time(blk), .trigger_delay_cycles(tdc),
    .ramp_active(ract), .angle_out(angle_out), .angle_source(src));

  fcr_pwm_partner u_fcr_pwm_partner (.pclk(pclk), .presetn(presetn), .tick_en(tick_en), .est_set(est_set),
    .pwm_tick(pwm_tick), .estimated_angle(est));

  always #25 pclk = ~pclk;

  always @(posedge pclk) begin
    if (ppc === 1'b1) pc++;
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [47:0] s, input logic [47:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : check

  task automatic apb(input logic w, input logic [15:0] i, input logic [7:0] d, output logic [7:0] r,
                     output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {i, 2'b00};
    pwdata  <= {24'h000000, d};
    pstrb   <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    apb(1'b1, i, d, r, e);
  endtask : wr

  task automatic rd(input logic [15:0] i, input logic [7:0] x, input logic xe);
    logic [7:0] r;
    logic       e;
    apb(1'b0, i, 8'h00, r, e);
    check(r, x);
    check(e, xe);
  endtask : rd

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    m_spd  = 0;
    m_acc  = 0;
    m_ol   = 0;
    m_fa   = 0;
    m_fs   = 0;
    m_cnt  = 0;
    m_c1   = 0;
    m_c2   = 0;
    m_rc   = 0;
    m_stp  = RST_STEP;
    m_post = 0;
    m_tog  = 0;
    mo     = '{3{RST_OFS}};
  endtask : do_reset

  // Reference engine: one step per tick, outputs compared the cycle after.
  task automatic run_ticks(input int t);
    int df;
    tick_en <= 1'b1;
    for (int k = 0; k < t; k++) begin
      do begin
        @(posedge pclk);
      end while (pwm_tick !== 1'b1);
      if (m_c2[B_ALT] && m_c1[3:2] != TOPO_SINGLE) m_tog = ~m_tog;
      if (m_c1[B_RAMP]) begin
        m_spd = m_spd + {16'h0000, m_acc};
        m_ol  = m_ol + m_spd[31:16];
        m_ang = m_ol;
        m_src = SRC_RAMP;
        m_cnt++;
        if (m_cnt >= m_rc * 256) begin
          m_c1[B_RAMP] = 1'b0;
          m_post = 1'b1;
        end
      end else if (!m_c1[B_ANGLE_SOURCE_SELECT]) begin
        m_ol  = m_ol + m_spd[31:16];
        m_ang = m_ol;
        m_src = SRC_PULL;
      end else if (m_post) begin
        df = int'($signed(est_set - m_ol));
        if ((df < 0 ? -df : df) <= m_stp) begin
          m_ang  = est_set;
          m_src  = SRC_EST;
          m_post = 1'b0;
        end else begin
          m_ol  = (df < 0) ? m_ol - m_stp : m_ol + m_stp;
          m_ang = m_ol;
          m_src = SRC_SMOOTH;
        end
      end else if (m_c1[B_ESTIMATOR_FORCED_START_EN] && below) begin
        m_fs  = (m_fs + finc > fhold) ? fhold : m_fs + finc;
        m_fa  = m_fa + m_fs[15:0];
        m_ang = m_fa;
        m_src = SRC_FORCED;
      end else begin
        m_ang = est_set;
        m_fa  = est_set;
        m_fs  = -int'(finc);
        m_src = SRC_EST;
      end
      #1;
      check(angle_out, m_ang);
      check(src, m_src);
      check(ract, m_c1[B_RAMP]);
      check(tog, m_tog);
    end
    tick_en <= 1'b0;
  endtask : run_ticks

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    seed = $urandom(32'hDAF9A61B);
    do_reset();
    foreach (rv[k]) rd(IDX_CR1 + 16'(k), rv[k], 1'b0);
    check({ofa, ofb, ofc, src}, {RST_OFS, RST_OFS, RST_OFS, SRC_PULL});
    rd(16'h40AE, 8'h00, 1'b1);
    rd(16'h409F, 8'h00, 1'b1);
    $display("reset and map test done");
    for (int k = 0; k < 8; k++) begin
      c1 = 8'($urandom()) & 8'hDF;
      c2 = 8'($urandom()) & 8'hBF;
      if (c1[3:2] == TOPO_SINGLE) c2[B_DSV] = 1'b0;
      v = 8'($urandom());
      wr(IDX_CR1, c1);
      wr(IDX_CR2, c2);
      wr(IDX_WMIN, v);
      wr(IDX_NPT, ~v);
      wr(IDX_BLANK, v ^ 8'h5A);
      rd(IDX_CR1, c1, 1'b0);
      rd(IDX_CR2, c2, 1'b0);
      check({ovm, sps, svs, topo}, {c1[B_OVM], c1[1:0], c1[3:2]});
      check({ets, qpd, dpd, alt}, {c2[B_ESTIMATOR_TYPE_SELECT], c2[B_QD], c2[B_DD], c2[B_ALT]});
      check(dsv, c2[B_DSV] && c1[3:2] != TOPO_SINGLE);
      check({wmin, npt, blk}, {v, ~v, v ^ 8'h5A});
    end
    $display("field test done");
    for (int t = 0; t < 4; t++) begin
      w16 = 16'($urandom());
      wr(IDX_CR2, 8'(t << 2));
      wr(IDX_OFS_H, w16[15:8]);
      wr(IDX_OFS_L, w16[7:0]);
      mo[t == 1 ? 1 : t == 2 ? 2 : 0] = w16[14:0];
      rd(IDX_OFS_H, {1'b0, w16[14:8]}, 1'b0);
      check({ofa, ofb, ofc}, {mo[1], mo[2], mo[0]});
    end
    k0 = pc;
    wr(IDX_CR2, 8'h40);
    repeat (3) @(posedge pclk);
    check(pc - k0, 1);
    rd(IDX_CR2, 8'h00, 1'b0);
    $display("offset and peak clear test done");
    foreach (dl[k]) for (int s = 0; s < 2; s++) begin
      wr(IDX_CR1, s ? 8'h0C : 8'h00);
      wr(IDX_TDLY, dl[k]);
      repeat (2) @(posedge pclk);
      check(tdc, s ? (dl[k][7] ? 9'(-int'(dl[k][6:0])) : {2'b00, dl[k][6:0]}) : {dl[k][7], dl[k]});
    end
    $display("trigger delay test done");
    do_reset();
    w16 = 16'($urandom());
    wr(IDX_ACC_H, w16[15:8]);
    wr(IDX_ACC_L, w16[7:0]);
    wr(IDX_SPD_H, 8'h00);
    wr(IDX_SPD_L, 8'h10);
    wr(IDX_RCNT, 8'h01);
    wr(IDX_CR2, 8'h10);
    wr(IDX_CR1, 8'h24);
    m_acc = w16;
    m_spd = 32'h00100000;
    m_rc  = 8'h01;
    m_c2  = 8'h10;
    m_c1  = 8'h24;
    run_ticks(262);
    rd(IDX_CR1, 8'h04, 1'b0);
    $display("ramp test done");
    do_reset();
    est_set <= 16'h0040;
    stp = 8'($urandom_range(2, 9));
    wr(IDX_STEP, stp);
    wr(IDX_CR1, 8'h30);
    m_stp = stp;
    m_c1  = 8'h30;
    run_ticks(40);
    $display("smooth switch test done");
    do_reset();
    finc    <= 16'h0020;
    fhold   <= 16'h0050;
    est_set <= 16'h1234;
    wr(IDX_CR1, 8'h50);
    m_c1 = 8'h50;
    run_ticks(3);
    @(posedge pclk);
    below <= 1'b1;
    run_ticks(8);
    @(posedge pclk);
    below <= 1'b0;
    run_ticks(2);
    $display("forced start test done");
    final_report();
  end
endmodule : fcr_regs_tb_top
